/* design/sol_supervisor.sv */
// Supervisor output logic: reset, rail-fault and watchdog output generation
//
// Summary of operation
// - Three outputs active low, open-drain or pullup
// - All outputs low during power-up lockout
// - Output with no sources stays asserted
// - Reset deasserts when all enabled sources good
// - Primary good means input above threshold
// - Reset held low for programmed delay
// - Three-bit code selects eight delay values
// - Reset type bit: one open-drain
// - Reset source bits: manual, fault, inputs
// - Config bit seven adds watchdog dependency
// - Fault output selects manual, reset, secondaries
// - Overvoltage good means input below threshold
// - Manual reset asserts, held for delay
// - Margin hold freezes every output
// - Margin hold overrides manual reset
// - Auxiliary input never affects outputs
// - Reference bit set selects external
// - Secondary mode bit: one means overvoltage
// - Fault output has own delay, type
// - Fault source bits two to seven secondaries
`timescale 1ns/100ps
module sol_supervisor #(
  parameter int TICK_CYCLES = sol_pkg::SOL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic manual_reset_n,
  input wire logic margin_hold_n,
  input wire logic watchdog_expired_n,
  input wire sol_pkg::sol_det_t monitor_inputs,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output sol_pkg::sol_pin_t sys_reset_pin,
  output sol_pkg::sol_pin_t rail_fault_pin,
  output sol_pkg::sol_pin_t watchdog_pin,
  output logic ref_external_sel
);

  typedef struct packed {
    logic [14:0] sync1;
    logic [14:0] sync2;
    logic [15:0] tick_cnt;
    logic [20:0] rst_cnt;
    logic [20:0] flt_cnt;
    logic [7:0] sec_mode;
    logic [7:0] rst_src;
    logic [7:0] rst_cfg;
    logic [7:0] flt_src;
    logic [7:0] flt_cfg;
    logic [7:0] wdg_cfg;
    logic [7:0] ref_sel;
    logic [7:0] rd_data;
    logic sys_reset_n;
    logic rail_fault_n;
    logic watchdog_n;
    logic rst_pu;
    logic flt_pu;
    logic wdg_pu;
  } sol_state_t;

  sol_state_t state_q;
  sol_state_t state_d;

  function automatic logic [20:0] hold_ticks(input logic [2:0] code);
    logic [20:0] t;
    t = sol_pkg::SOL_DLY_US_0;
    unique case (code)
      3'h0: t = sol_pkg::SOL_DLY_US_0;
      3'h1: t = sol_pkg::SOL_DLY_US_1;
      3'h2: t = sol_pkg::SOL_DLY_US_2;
      3'h3: t = sol_pkg::SOL_DLY_US_3;
      3'h4: t = sol_pkg::SOL_DLY_US_4;
      3'h5: t = sol_pkg::SOL_DLY_US_5;
      3'h6: t = sol_pkg::SOL_DLY_US_6;
      3'h7: t = sol_pkg::SOL_DLY_US_7;
    endcase
    return t;
  endfunction

  // Returns {deasserted, count}; any bad source restarts the whole delay.
  // A released output stays released if its delay code is raised later.
  function automatic logic [21:0] hold_step(input logic [20:0] cnt, input logic good,
                                            input logic [2:0] code, input logic tick,
                                            input logic rel);
    logic [21:0] r;
    r = {1'b0, 21'h00000};
    if (good) begin
      if (rel || cnt >= hold_ticks(code)) begin
        r = {1'b1, cnt};
      end else begin
        r = {1'b0, cnt + {20'h00000, tick}};
      end
    end
    return r;
  endfunction

  logic mr_ok;
  logic hold;
  logic wdg_ok;
  logic [5:0] prim_ok;
  logic [5:0] sec_ok;
  logic rst_good;
  logic flt_good;
  logic tick;
  logic [21:0] rst_step;
  logic [21:0] flt_step;

  // Synchronised inputs; the auxiliary input has no path here at all
  assign mr_ok = state_q.sync2[14];
  assign hold = ~state_q.sync2[13];
  assign wdg_ok = state_q.sync2[12];
  assign prim_ok = state_q.sync2[11:6];
  // Overvoltage mode inverts the sense of a good secondary result
  assign sec_ok = state_q.sync2[5:0] ^ state_q.sec_mode[5:0];
  assign tick = (state_q.tick_cnt == 16'(TICK_CYCLES - 1));

  always_comb begin
    logic [7:0] rst_bad;
    logic [7:0] flt_bad;
    logic rst_any;
    logic flt_any;
    rst_bad = state_q.rst_src & ~{prim_ok, state_q.rail_fault_n, mr_ok};
    flt_bad = state_q.flt_src & ~{sec_ok, state_q.sys_reset_n, mr_ok};
    rst_any = (|state_q.rst_src) | state_q.rst_cfg[sol_pkg::SOL_CFG_WDG_BIT];
    flt_any = |state_q.flt_src;
    // No source selected means never good, so the output stays low
    rst_good = rst_any & ~(|rst_bad)
      & ~(state_q.rst_cfg[sol_pkg::SOL_CFG_WDG_BIT] & ~wdg_ok);
    flt_good = flt_any & ~(|flt_bad);
  end

  assign rst_step = hold_step(state_q.rst_cnt, rst_good,
                              state_q.rst_cfg[3:1], tick, state_q.sys_reset_n);
  assign flt_step = hold_step(state_q.flt_cnt, flt_good,
                              state_q.flt_cfg[3:1], tick, state_q.rail_fault_n);

  always_comb begin
    state_d = state_q;
    // First stage feeds only the second stage
    state_d.sync1 = {manual_reset_n, margin_hold_n, watchdog_expired_n,
                     monitor_inputs.prim_above, monitor_inputs.sec_above};
    state_d.sync2 = state_q.sync1;
    state_d.tick_cnt = tick ? 16'h0000 : state_q.tick_cnt + 16'h0001;

    if (reg_wr_en) begin
      unique case (reg_addr)
        sol_pkg::SOL_ADDR_SEC_MODE: state_d.sec_mode = reg_wr_data & sol_pkg::SOL_SEC_MODE_MASK;
        sol_pkg::SOL_ADDR_RST_SRC: state_d.rst_src = reg_wr_data;
        sol_pkg::SOL_ADDR_RST_CFG: state_d.rst_cfg = reg_wr_data & sol_pkg::SOL_CFG_MASK;
        sol_pkg::SOL_ADDR_FLT_SRC: state_d.flt_src = reg_wr_data;
        sol_pkg::SOL_ADDR_FLT_CFG: state_d.flt_cfg = reg_wr_data & sol_pkg::SOL_FLT_CFG_MASK;
        sol_pkg::SOL_ADDR_WDG_CFG: state_d.wdg_cfg = reg_wr_data;
        sol_pkg::SOL_ADDR_REF_SEL: state_d.ref_sel = reg_wr_data;
        default: ;
      endcase
    end

    unique case (reg_addr)
      sol_pkg::SOL_ADDR_SEC_MODE: state_d.rd_data = state_q.sec_mode;
      sol_pkg::SOL_ADDR_RST_SRC: state_d.rd_data = state_q.rst_src;
      sol_pkg::SOL_ADDR_RST_CFG: state_d.rd_data = state_q.rst_cfg;
      sol_pkg::SOL_ADDR_FLT_SRC: state_d.rd_data = state_q.flt_src;
      sol_pkg::SOL_ADDR_FLT_CFG: state_d.rd_data = state_q.flt_cfg;
      sol_pkg::SOL_ADDR_WDG_CFG: state_d.rd_data = state_q.wdg_cfg;
      sol_pkg::SOL_ADDR_REF_SEL: state_d.rd_data = state_q.ref_sel;
      default: state_d.rd_data = 8'h00;
    endcase

    // Margin hold freezes outputs and delay counters, so manual reset is ignored too
    if (!hold) begin
      state_d.rst_cnt = rst_step[20:0];
      state_d.sys_reset_n = rst_step[21];
      state_d.flt_cnt = flt_step[20:0];
      state_d.rail_fault_n = flt_step[21];
      state_d.watchdog_n = wdg_ok;
    end

    // Released line gets the weak pullup only when that type is chosen
    state_d.rst_pu = state_d.sys_reset_n
      & ~state_q.rst_cfg[sol_pkg::SOL_CFG_OD_BIT];
    state_d.flt_pu = state_d.rail_fault_n
      & ~state_q.flt_cfg[sol_pkg::SOL_CFG_OD_BIT];
    state_d.wdg_pu = state_d.watchdog_n
      & ~state_q.wdg_cfg[sol_pkg::SOL_CFG_OD_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Lockout: every output held low, counters cleared
      state_q <= '0;
      state_q.sync1 <= 15'h7FFF;
      state_q.sync2 <= 15'h7FFF;
      state_q.sec_mode <= sol_pkg::SOL_RST_SEC_MODE;
      state_q.rst_src <= sol_pkg::SOL_RST_RST_SRC;
      state_q.rst_cfg <= sol_pkg::SOL_RST_RST_CFG;
      state_q.flt_src <= sol_pkg::SOL_RST_FLT_SRC;
      state_q.flt_cfg <= sol_pkg::SOL_RST_FLT_CFG;
      state_q.wdg_cfg <= sol_pkg::SOL_RST_WDG_CFG;
      state_q.ref_sel <= sol_pkg::SOL_RST_REF_SEL;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rd_data = state_q.rd_data;
  assign sys_reset_pin = '{out_n: state_q.sys_reset_n, pullup_en: state_q.rst_pu};
  assign rail_fault_pin = '{out_n: state_q.rail_fault_n, pullup_en: state_q.flt_pu};
  assign watchdog_pin = '{out_n: state_q.watchdog_n, pullup_en: state_q.wdg_pu};
  assign ref_external_sel = state_q.ref_sel[sol_pkg::SOL_REF_EXT_BIT];

  sequence s_free;
    !hold;
  endsequence

  sequence s_released;
    !$past(state_q.sys_reset_n) ##0 state_q.sys_reset_n;
  endsequence

  a_lockout_low: assert property (@(posedge clk) rst |=>
    !state_q.sys_reset_n && !state_q.rail_fault_n && !state_q.watchdog_n)
    else $error("Outputs not low after lockout");

  a_no_source_low: assert property (@(posedge clk) disable iff (rst)
    (state_q.flt_src == 8'h00) && !state_q.rail_fault_n |=> !state_q.rail_fault_n)
    else $error("Fault output released with no source");

  a_reset_and: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 !rst_good |=> !state_q.sys_reset_n)
    else $error("Reset released with a bad source");

  a_delay_hold: assert property (@(posedge clk) disable iff (rst)
    s_released |-> $past(rst_good)
      && ($past(state_q.rst_cnt) >= hold_ticks($past(state_q.rst_cfg[3:1]))))
    else $error("Reset released before its delay");

  a_mr_assert: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 !mr_ok && state_q.rst_src[sol_pkg::SOL_SRC_MR_BIT] |=> !state_q.sys_reset_n)
    else $error("Manual reset did not assert reset");

  a_margin_freeze: assert property (@(posedge clk) disable iff (rst)
    hold |=> $stable(state_q.sys_reset_n) && $stable(state_q.rail_fault_n)
      && $stable(state_q.watchdog_n))
    else $error("Output moved under margin hold");

  a_od_no_pullup: assert property (@(posedge clk) disable iff (rst)
    $past(state_q.rst_cfg[sol_pkg::SOL_CFG_OD_BIT]) |-> !state_q.rst_pu)
    else $error("Pullup on an open-drain reset output");

  a_ov_good: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 state_q.flt_src[2] && state_q.sec_mode[0] && state_q.sync2[0]
    |=> !state_q.rail_fault_n)
    else $error("Overvoltage did not assert fault output");

  a_wdog_dep: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 state_q.rst_cfg[sol_pkg::SOL_CFG_WDG_BIT] && !wdg_ok |=> !state_q.sys_reset_n)
    else $error("Watchdog did not assert reset");

  a_ref_select: assert property (@(posedge clk) disable iff (rst)
    reg_wr_en && (reg_addr == sol_pkg::SOL_ADDR_REF_SEL)
    |=> ref_external_sel == $past(reg_wr_data[sol_pkg::SOL_REF_EXT_BIT]))
    else $error("Reference select not taken from write");

  sequence s_flt_released;
    !$past(state_q.rail_fault_n) ##0 state_q.rail_fault_n;
  endsequence

  a_prim_low: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 |(state_q.rst_src[7:2] & ~prim_ok) |=> !state_q.sys_reset_n)
    else $error("Low primary input did not assert reset");

  a_reset_peer: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 state_q.rst_src[sol_pkg::SOL_SRC_PEER_BIT] && !state_q.rail_fault_n
    |=> !state_q.sys_reset_n)
    else $error("Fault output did not assert reset");

  a_pullup_weak: assert property (@(posedge clk) disable iff (rst)
    state_q.sys_reset_n && !$past(state_q.rst_cfg[sol_pkg::SOL_CFG_OD_BIT])
    |-> state_q.rst_pu)
    else $error("Weak pullup missing on released reset");

  a_fault_mr: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 !mr_ok && state_q.flt_src[sol_pkg::SOL_SRC_MR_BIT] |=> !state_q.rail_fault_n)
    else $error("Manual reset did not assert fault output");

  a_fault_peer: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 state_q.flt_src[sol_pkg::SOL_SRC_PEER_BIT] && !state_q.sys_reset_n
    |=> !state_q.rail_fault_n)
    else $error("Reset did not assert fault output");

  a_sec_uv: assert property (@(posedge clk) disable iff (rst)
    s_free ##0 state_q.flt_src[2] && !state_q.sec_mode[0] && !state_q.sync2[0]
    |=> !state_q.rail_fault_n)
    else $error("Undervoltage did not assert fault output");

  a_fault_delay: assert property (@(posedge clk) disable iff (rst)
    s_flt_released |-> $past(flt_good)
      && ($past(state_q.flt_cnt) >= hold_ticks($past(state_q.flt_cfg[3:1]))))
    else $error("Fault output released before its delay");

  a_fault_od: assert property (@(posedge clk) disable iff (rst)
    $past(state_q.flt_cfg[sol_pkg::SOL_CFG_OD_BIT]) |-> !state_q.flt_pu)
    else $error("Pullup on an open-drain fault output");

  a_wdg_follow: assert property (@(posedge clk) disable iff (rst)
    s_free |=> state_q.watchdog_n == $past(wdg_ok))
    else $error("Watchdog output does not follow its input");

endmodule // sol_supervisor

/* pkg/sol_pkg.sv */
// Package for the supervisor output logic: register map, delays and carriers
package sol_pkg;

  // Register indices on the register port
  localparam logic [7:0] SOL_ADDR_SEC_MODE = 8'h0E;
  localparam logic [7:0] SOL_ADDR_RST_SRC = 8'h11;
  localparam logic [7:0] SOL_ADDR_RST_CFG = 8'h12;
  localparam logic [7:0] SOL_ADDR_FLT_SRC = 8'h13;
  localparam logic [7:0] SOL_ADDR_FLT_CFG = 8'h14;
  localparam logic [7:0] SOL_ADDR_WDG_CFG = 8'h15;
  localparam logic [7:0] SOL_ADDR_REF_SEL = 8'h16;

  // Values after reset
  localparam logic [7:0] SOL_RST_SEC_MODE = 8'h00;
  localparam logic [7:0] SOL_RST_RST_SRC = 8'h00;
  localparam logic [7:0] SOL_RST_RST_CFG = 8'h00;
  localparam logic [7:0] SOL_RST_FLT_SRC = 8'h00;
  localparam logic [7:0] SOL_RST_FLT_CFG = 8'h00;
  localparam logic [7:0] SOL_RST_WDG_CFG = 8'h00;
  localparam logic [7:0] SOL_RST_REF_SEL = 8'h00;

  // Field positions
  localparam int SOL_SRC_MR_BIT = 0;
  localparam int SOL_SRC_PEER_BIT = 1;
  localparam int SOL_CFG_OD_BIT = 0;
  localparam int SOL_CFG_DLY_LSB = 1;
  localparam int SOL_CFG_WDG_BIT = 7;
  localparam int SOL_REF_EXT_BIT = 7;
  localparam logic [7:0] SOL_SEC_MODE_MASK = 8'h3F;
  localparam logic [7:0] SOL_CFG_MASK = 8'h8F;
  localparam logic [7:0] SOL_FLT_CFG_MASK = 8'h0F;

  // Timebase: one tick per microsecond at 20 MHz
  localparam int SOL_CLK_NS = 50;
  localparam int SOL_TICK_NS = 1000;
  localparam int SOL_TICK_CYCLES = (SOL_TICK_NS + SOL_CLK_NS - 1) / SOL_CLK_NS;

  // Deassertion delays in microseconds
  localparam logic [20:0] SOL_DLY_US_0 = 21'd25;
  localparam logic [20:0] SOL_DLY_US_1 = 21'd1560;
  localparam logic [20:0] SOL_DLY_US_2 = 21'd6250;
  localparam logic [20:0] SOL_DLY_US_3 = 21'd25000;
  localparam logic [20:0] SOL_DLY_US_4 = 21'd50000;
  localparam logic [20:0] SOL_DLY_US_5 = 21'd200000;
  localparam logic [20:0] SOL_DLY_US_6 = 21'd400000;
  localparam logic [20:0] SOL_DLY_US_7 = 21'd1600000;

  // Detector results, one bit per monitored input
  typedef struct packed {
    logic [5:0] prim_above;
    logic [5:0] sec_above;
  } sol_det_t;

  // One supervisory output pin: level and weak pullup enable
  typedef struct packed {
    logic out_n;
    logic pullup_en;
  } sol_pin_t;

endpackage

/* sim/sol_host_model.sv */
// Host-side model: resolves the supervisory pins into the levels the processor sees
`timescale 1ns/100ps
module sol_host_model (
  input wire sol_pkg::sol_pin_t sys_reset_pin,
  input wire sol_pkg::sol_pin_t rail_fault_pin,
  output logic reset_line,
  output logic fault_line
);
  // Board pull-up assumed, so a released open-drain pin also reads high; an unknown stays unknown
  assign reset_line = sys_reset_pin.out_n ? 1'b1 : 1'b0;
  assign fault_line = rail_fault_pin.out_n ? 1'b1 : 1'b0;
endmodule // sol_host_model

/* sim/tb_top.sv */
// Self-checking testbench for the supervisor output logic
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mr_n = 1'b1;
  logic hold_n = 1'b1;
  logic wdg_n = 1'b1;
  sol_pkg::sol_det_t det = '0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  sol_pkg::sol_pin_t rst_pin, flt_pin, wdg_pin;
  logic ref_sel, reset_line, fault_line;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int dl [3] = '{25, 1560, 6250};

  always #25 clk = ~clk;

  // One tick per clock keeps the longest tested delay to a few thousand cycles
  sol_supervisor #(.TICK_CYCLES(1)) uut (.clk(clk), .rst(rst), .manual_reset_n(mr_n),
    .margin_hold_n(hold_n), .watchdog_expired_n(wdg_n), .monitor_inputs(det),
    .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
    .sys_reset_pin(rst_pin), .rail_fault_pin(flt_pin), .watchdog_pin(wdg_pin),
    .ref_external_sel(ref_sel));
  sol_host_model host (.sys_reset_pin(rst_pin), .rail_fault_pin(flt_pin),
    .reset_line(reset_line), .fault_line(fault_line));

  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk("register read", exp, rdata);
  endtask

  // Counts cycles from an input going good until the output line is released
  task automatic rise(input int d, input logic flt);
    int n;
    n = 0;
    while ((flt ? fault_line : reset_line) !== 1'b1 && n < d + 8) begin
      @(negedge clk);
      n++;
    end
    chk("release delay in range", {7'h00, n >= d && n <= d + 6}, 8'h01);
  endtask

  task automatic fall(input logic flt);
    repeat (4) @(negedge clk);
    chk("output asserted", 8'h00, {7'h00, flt ? fault_line : reset_line});
  endtask

  task automatic t_regs();
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h8F);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h0F);
    wr(8'h0E, 8'hFF);
    rd(8'h0E, 8'h3F);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    wr(8'h16, 8'h80);
    rd(8'h16, 8'h80);
    chk("reference select", 8'h01, {7'h00, ref_sel});
    wr(8'h16, 8'h00);
    chk("reference internal", 8'h00, {7'h00, ref_sel});
    wr(8'h12, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h0E, 8'h00);
    repeat (40) @(negedge clk);
    chk("no source reset", 8'h00, {7'h00, reset_line});
    chk("no source fault", 8'h00, {7'h00, fault_line});
  endtask

  // Delay codes 0 to 2 in turn, with the output type bit toggled between runs
  task automatic t_delay();
    wr(8'h11, 8'h04);
    for (int c = 0; c < 3; c++) begin
      wr(8'h12, 8'(c * 2 + (c % 2)));
      det.prim_above[0] = 1'b0;
      fall(1'b0);
      det.prim_above[0] = 1'b1;
      rise(dl[c], 1'b0);
      chk("reset pullup", 8'(1 - c % 2), {7'h00, rst_pin.pullup_en});
    end
    wr(8'h12, 8'h00);
  endtask

  task automatic t_margin();
    wr(8'h11, 8'h05);
    repeat (30) @(negedge clk);
    hold_n = 1'b0;
    repeat (3) @(negedge clk);
    mr_n = 1'b0;
    det.prim_above[0] = 1'b0;
    repeat (10) @(negedge clk);
    chk("held reset", 8'h01, {7'h00, reset_line});
    hold_n = 1'b1;
    fall(1'b0);
    det.prim_above[0] = 1'b1;
    mr_n = 1'b1;
    rise(25, 1'b0);
  endtask

  task automatic t_wdg();
    wr(8'h11, 8'h04);
    wr(8'h12, 8'h80);
    wdg_n = 1'b0;
    fall(1'b0);
    chk("watchdog pin", 8'h00, {7'h00, wdg_pin.out_n});
    wdg_n = 1'b1;
    rise(25, 1'b0);
    chk("watchdog pullup", 8'h01, {7'h00, wdg_pin.pullup_en});
    wr(8'h15, 8'h01);
    rd(8'h15, 8'h01);
    chk("watchdog open drain", 8'h00, {7'h00, wdg_pin.pullup_en});
  endtask

  task automatic t_fault();
    wr(8'h0E, 8'h01);
    wr(8'h13, 8'h04);
    rd(8'h13, 8'h04);
    wr(8'h14, 8'h01);
    det.sec_above[0] = 1'b1;
    fall(1'b1);
    det.sec_above[0] = 1'b0;
    rise(25, 1'b1);
    chk("fault pullup", 8'h00, {7'h00, flt_pin.pullup_en});
    wr(8'h0E, 8'h00);
    fall(1'b1);
    wr(8'h13, 8'h02);
    rise(25, 1'b1);
    // The watchdog bit is a source too, so both registers are cleared
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    fall(1'b0);
    fall(1'b1);
  endtask

  initial begin
    repeat (11) @(negedge clk);
    chk("lockout reset", 8'h00, {7'h00, rst_pin.out_n});
    chk("lockout fault", 8'h00, {7'h00, flt_pin.out_n});
    chk("lockout watchdog", 8'h00, {7'h00, wdg_pin.out_n});
    @(negedge clk);
    rst = 1'b0;
    rd(8'h11, 8'h00);
    t_regs();
    t_delay();
    t_margin();
    t_wdg();
    t_fault();
    summarize();
  end
endmodule // tb_top
